/* File: pkg/oag_pkg.sv */
package oag_pkg;

  // Addressing modes
  typedef enum logic [4:0] {
    OAG_INHERENT,
    OAG_IMMEDIATE,
    OAG_DIR_SHORT,
    OAG_DIR_LONG,
    OAG_IDX_NOOFF,
    OAG_IDX_SHORT,
    OAG_IDX_LONG,
    OAG_IND_SHORT,
    OAG_IND_LONG,
    OAG_INDIDX_SHORT,
    OAG_INDIDX_LONG,
    OAG_REL_DIR,
    OAG_REL_IND,
    OAG_BIT_DIR,
    OAG_BIT_IND,
    OAG_BITREL_DIR,
    OAG_BITREL_IND
  } oag_mode_t;

  // Operand class of the instruction
  typedef enum logic [1:0] {
    OAG_CLS_LOAD,
    OAG_CLS_RMW,
    OAG_CLS_JUMP
  } oag_cls_t;

  localparam logic [15:0] OAG_ADDR_RST = 16'h0000;
  localparam logic [7:0]  OAG_BYTE_RST = 8'h00;
  localparam logic [2:0]  OAG_LEN_RST  = 3'h0;
  localparam logic [7:0]  OAG_PAGE0_HI = 8'h00;

endpackage : oag_pkg

/* File: design/oag_byte_hold.sv */
`timescale 1ns/1ps
`default_nettype none

// Holds one fetched byte; read data comes out of a register
module oag_byte_hold
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Read side
  output logic      [7:0] rd_data
);
  import oag_pkg::*;

  typedef struct packed {
    logic [7:0] data;
  } oag_hold_t;

  oag_hold_t state_ff;
  oag_hold_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    if (wr_en)
    begin
      nxt_state.data = wr_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_ff.data <= OAG_BYTE_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data = state_ff.data;

endmodule : oag_byte_hold

`default_nettype wire

/* File: design/oag_core.sv */
`timescale 1ns/1ps
`default_nettype none

module oag_core
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Decode request from fetch unit
  input  wire logic              dec_start,
  input  wire oag_pkg::oag_mode_t dec_mode,
  input  wire oag_pkg::oag_cls_t  dec_cls,
  input  wire logic              dec_use_y,
  input  wire logic [15:0]       dec_pc,
  input  wire logic [7:0]        idx_x,
  input  wire logic [7:0]        idx_y,
  // Instruction byte stream
  output logic                   ibyte_req,
  input  wire logic              ibyte_vld,
  input  wire logic [7:0]        ibyte_data,
  // Pointer read from data memory, first byte in page zero
  output logic                   mem_req,
  output logic [15:0]            mem_addr,
  input  wire logic              mem_vld,
  input  wire logic [7:0]        mem_data,
  // Result
  output logic                   ea_done,
  output logic [15:0]            ea_addr,
  output logic [7:0]             ea_imm,
  output logic                   ea_is_imm,
  output logic [2:0]             ea_len,
  output logic                   ea_illegal
);
  import oag_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_OPB1,
    S_OPB2,
    S_PTR1,
    S_PTR2,
    S_DONE
  } oag_st_t;

  typedef struct packed {
    oag_st_t   st;
    oag_mode_t mode;
    logic [7:0]  idx;
    logic [15:0] pc;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic        ireq;
    logic        mreq;
    logic [15:0] maddr;
    logic        done;
    logic [15:0] addr;
    logic [7:0]  imm;
    logic        is_imm;
    logic [2:0]  len;
    logic        illegal;
  } oag_state_t;

  oag_state_t state_ff;
  oag_state_t nxt_state;
  logic [7:0] ptr_lo;

  // Operand bytes after the opcode, excluding any prefix byte
  function automatic logic [2:0] op_bytes(input oag_mode_t m);
    unique case (m)
      OAG_INHERENT, OAG_IDX_NOOFF:                 op_bytes = 3'h0;
      OAG_DIR_LONG, OAG_IDX_LONG, OAG_BITREL_DIR:  op_bytes = 3'h2;
      OAG_BITREL_IND:                              op_bytes = 3'h2;
      default:                                     op_bytes = 3'h1;
    endcase
  endfunction : op_bytes

  // Unsigned 8-bit index plus 16-bit base
  function automatic logic [15:0] idx_add(input logic [7:0] i,
                                          input logic [15:0] b);
    idx_add = b + {8'h00, i};
  endfunction : idx_add

  function automatic logic is_long(input oag_mode_t m);
    is_long = (m == OAG_DIR_LONG) || (m == OAG_IDX_LONG) ||
              (m == OAG_IND_LONG) || (m == OAG_INDIDX_LONG);
  endfunction : is_long

  function automatic logic is_indexed(input oag_mode_t m);
    is_indexed = (m == OAG_IDX_NOOFF) || (m == OAG_IDX_SHORT) ||
                 (m == OAG_IDX_LONG) || (m == OAG_INDIDX_SHORT) ||
                 (m == OAG_INDIDX_LONG);
  endfunction : is_indexed

  function automatic logic is_ptr(input oag_mode_t m);
    is_ptr = (m == OAG_IND_SHORT) || (m == OAG_IND_LONG) ||
             (m == OAG_INDIDX_SHORT) || (m == OAG_INDIDX_LONG) ||
             (m == OAG_REL_IND) || (m == OAG_BIT_IND) ||
             (m == OAG_BITREL_IND);
  endfunction : is_ptr

  // Low pointer byte kept in its own register
  oag_byte_hold u_ptr_lo
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (state_ff.st == S_PTR2 && mem_vld),
    .wr_data (mem_data),
    .rd_data (ptr_lo)
  );

  always_comb
  begin
    logic [15:0] nxt_pc;
    logic [15:0] ptr_w;
    logic [15:0] base;
    nxt_pc = 16'h0000;
    ptr_w  = 16'h0000;
    base   = 16'h0000;
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    unique case (state_ff.st)
      S_IDLE:
      begin
        if (dec_start)
        begin
          nxt_state.mode    = dec_mode;
          nxt_state.idx     = dec_use_y ? idx_y : idx_x;
          nxt_state.pc      = dec_pc;
          nxt_state.is_imm  = (dec_mode == OAG_IMMEDIATE);
          nxt_state.illegal = (dec_cls == OAG_CLS_RMW) && is_long(dec_mode);
          nxt_state.len     = 3'h1 + op_bytes(dec_mode) +
                              {2'b00, is_ptr(dec_mode)} +
                              {2'b00, dec_use_y && is_indexed(dec_mode)};
          if (op_bytes(dec_mode) == 3'h0)
          begin
            nxt_state.st = S_DONE;
          end
          else
          begin
            nxt_state.st   = S_OPB1;
            nxt_state.ireq = 1'b1;
          end
        end
      end
      S_OPB1:
      begin
        if (ibyte_vld)
        begin
          nxt_state.b1 = ibyte_data;
          if (op_bytes(state_ff.mode) == 3'h2)
          begin
            nxt_state.st = S_OPB2;
          end
          else if (is_ptr(state_ff.mode))
          begin
            nxt_state.ireq  = 1'b0;
            nxt_state.mreq  = 1'b1;
            nxt_state.maddr = {OAG_PAGE0_HI, ibyte_data};
            nxt_state.st    = S_PTR1;
          end
          else
          begin
            nxt_state.ireq = 1'b0;
            nxt_state.st   = S_DONE;
          end
        end
      end
      S_OPB2:
      begin
        if (ibyte_vld)
        begin
          nxt_state.b2   = ibyte_data;
          nxt_state.ireq = 1'b0;
          if (state_ff.mode == OAG_BITREL_IND)
          begin
            nxt_state.mreq  = 1'b1;
            nxt_state.maddr = {OAG_PAGE0_HI, state_ff.b1};
            nxt_state.st    = S_PTR1;
          end
          else
          begin
            nxt_state.st = S_DONE;
          end
        end
      end
      S_PTR1:
      begin
        if (mem_vld)
        begin
          nxt_state.b1 = mem_data;
          if (state_ff.mode == OAG_IND_LONG ||
              state_ff.mode == OAG_INDIDX_LONG)
          begin
            nxt_state.maddr = state_ff.maddr + 16'h0001;
            nxt_state.st    = S_PTR2;
          end
          else
          begin
            nxt_state.mreq = 1'b0;
            nxt_state.st   = S_DONE;
          end
        end
      end
      S_PTR2:
      begin
        if (mem_vld)
        begin
          nxt_state.mreq = 1'b0;
          nxt_state.b2   = mem_data;
          nxt_state.st   = S_DONE;
        end
      end
      S_DONE:
      begin
        nxt_pc = state_ff.pc + {13'h0000, state_ff.len};
        ptr_w  = {state_ff.b1, state_ff.b2};
        base   = {8'h00, state_ff.b1};
        unique case (state_ff.mode)
          OAG_IMMEDIATE:    nxt_state.imm  = state_ff.b1;
          OAG_DIR_SHORT:    nxt_state.addr = base;
          OAG_DIR_LONG:     nxt_state.addr = ptr_w;
          OAG_IDX_NOOFF:    nxt_state.addr = idx_add(state_ff.idx, 16'h0000);
          OAG_IDX_SHORT:    nxt_state.addr = idx_add(state_ff.idx, base);
          OAG_IDX_LONG:     nxt_state.addr = idx_add(state_ff.idx, ptr_w);
          OAG_IND_SHORT:    nxt_state.addr = base;
          OAG_IND_LONG:     nxt_state.addr = {state_ff.b1, ptr_lo};
          OAG_INDIDX_SHORT: nxt_state.addr = idx_add(state_ff.idx, base);
          OAG_INDIDX_LONG:
            nxt_state.addr = idx_add(state_ff.idx, {state_ff.b1, ptr_lo});
          OAG_REL_DIR, OAG_REL_IND:
            nxt_state.addr = nxt_pc + {{8{state_ff.b1[7]}}, state_ff.b1};
          OAG_BITREL_DIR:
          begin
            nxt_state.addr = {8'h00, state_ff.b1};
            nxt_state.imm  = state_ff.b2;
          end
          OAG_BITREL_IND:
          begin
            nxt_state.addr = {8'h00, state_ff.b1};
            nxt_state.imm  = state_ff.b2;
          end
          OAG_BIT_DIR, OAG_BIT_IND: nxt_state.addr = base;
          default:          nxt_state.addr = OAG_ADDR_RST;
        endcase
        nxt_state.done = 1'b1;
        nxt_state.st   = S_IDLE;
      end
      default:
        nxt_state.st = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_ff         <= '0;
      state_ff.st      <= S_IDLE;
      state_ff.mode    <= OAG_INHERENT;
      state_ff.addr    <= OAG_ADDR_RST;
      state_ff.len     <= OAG_LEN_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign ibyte_req  = state_ff.ireq;
  assign mem_req    = state_ff.mreq;
  assign mem_addr   = state_ff.maddr;
  assign ea_done    = state_ff.done;
  assign ea_addr    = state_ff.addr;
  assign ea_imm     = state_ff.imm;
  assign ea_is_imm  = state_ff.is_imm;
  assign ea_len     = state_ff.len;
  assign ea_illegal = state_ff.illegal;

endmodule : oag_core

`default_nettype wire

/* File: sim/oag_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module oag_core_monitor
(
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rst,
  // Decode request
  input wire logic               dec_start,
  input wire oag_pkg::oag_mode_t dec_mode,
  input wire oag_pkg::oag_cls_t  dec_cls,
  input wire logic               dec_use_y,
  input wire logic [7:0]         idx_x,
  input wire logic [7:0]         idx_y,
  // Fetch and memory
  input wire logic               ibyte_req,
  input wire logic               ibyte_vld,
  input wire logic               mem_req,
  input wire logic [15:0]        mem_addr,
  input wire logic               mem_vld,
  // Result
  input wire logic               ea_done,
  input wire logic [15:0]        ea_addr,
  input wire logic               ea_is_imm,
  input wire logic [2:0]         ea_len,
  input wire logic               ea_illegal
);
  import oag_pkg::*;
  logic      busy_ff, y_ff, rd_ff;
  oag_mode_t m_ff;
  oag_cls_t  c_ff;
  logic [7:0] i_ff;
  wire logic go = dec_start && !busy_ff;
  wire logic lp = m_ff inside {OAG_IND_LONG, OAG_INDIDX_LONG};
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      busy_ff <= 1'b0;
    else if (go)
      busy_ff <= 1'b1;
    else if (ea_done)
      busy_ff <= 1'b0;
    if (rst || go)
      rd_ff <= 1'b0;
    else if (mem_req && mem_vld)
      rd_ff <= 1'b1;
    if (go)
    begin
      m_ff <= dec_mode;
      c_ff <= dec_cls;
      y_ff <= dec_use_y;
      i_ff <= dec_use_y ? idx_y : idx_x;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_inh;
    go && dec_mode == OAG_INHERENT && !dec_use_y;
  endsequence
  sequence s_ptr_hi;
    mem_req && mem_vld && !rd_ff && lp;
  endsequence
  property p_inh;
    s_inh |=> !ea_done ##1 ea_done && ea_len == 3'h1;
  endproperty
  a_inh: assert property (p_inh) else $error("inherent result");
  property p_nobyte;
    busy_ff && m_ff inside {OAG_INHERENT, OAG_IDX_NOOFF}
      |-> !ibyte_req && !mem_req;
  endproperty
  a_nobyte: assert property (p_nobyte) else $error("extra fetch");
  property p_imm;
    ea_done && ea_is_imm |-> ea_len == 3'h2;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate length");
  property p_noidx;
    ea_done && m_ff == OAG_IDX_NOOFF
      |-> ea_addr == {8'h00, i_ff} && ea_len == 3'h1 + {2'h0, y_ff};
  endproperty
  a_noidx: assert property (p_noidx) else $error("no-offset index");
  property p_dirs;
    ea_done && m_ff == OAG_DIR_SHORT |-> ea_addr[15:8] == 8'h00;
  endproperty
  a_dirs: assert property (p_dirs) else $error("short direct page");
  property p_pz;
    mem_req && !rd_ff |-> mem_addr[15:8] == 8'h00;
  endproperty
  a_pz: assert property (p_pz) else $error("pointer not page zero");
  property p_ptrw;
    s_ptr_hi |=> mem_req && mem_addr == $past(mem_addr) + 16'h1;
  endproperty
  a_ptrw: assert property (p_ptrw) else $error("word order");
  property p_hold;
    mem_req && !mem_vld |=> mem_req && $stable(mem_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("read dropped");
  property p_rmw;
    ea_done && m_ff inside {OAG_DIR_SHORT, OAG_DIR_LONG}
      |-> ea_illegal == (c_ff == OAG_CLS_RMW && m_ff == OAG_DIR_LONG);
  endproperty
  a_rmw: assert property (p_rmw) else $error("long mode flag");
endmodule : oag_core_monitor
bind oag_core oag_core_monitor oag_core_monitor_i (.ref_clk, .rst,
  .dec_start, .dec_mode, .dec_cls, .dec_use_y, .idx_x, .idx_y,
  .ibyte_req, .ibyte_vld, .mem_req, .mem_addr, .mem_vld, .ea_done,
  .ea_addr, .ea_is_imm, .ea_len, .ea_illegal);
`default_nettype wire

/* File: sim/oag_far.sv */
`timescale 1ns/1ps
`default_nettype none
module oag_far
(
  // Clock and control
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        restart,
  input  wire logic        slow,
  // Instruction byte stream
  input  wire logic        ibyte_req,
  output logic             ibyte_vld,
  output logic [7:0]       ibyte_data,
  // Data memory, pages zero and one
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_vld,
  output logic [7:0]       mem_data
);
  logic [7:0] ib [4];
  logic [7:0] mem [512];
  logic [1:0] k, w;
  wire logic go = !slow || w == 2'h3;
  // Data lines toggle when not valid, so stale bytes never look right
  always @(posedge ref_clk)
  begin
    ibyte_vld <= 1'b0;
    mem_vld <= 1'b0;
    ibyte_data <= ~ibyte_data;
    mem_data <= ~mem_data;
    w <= w + 2'h1;
    if (rst || restart)
      k <= 2'h0;
    if (rst)
    begin
      ibyte_data <= 8'h5A;
      mem_data <= 8'hA5;
      w <= 2'h0;
    end
    else if (ibyte_req && !ibyte_vld && go)
    begin
      ibyte_vld <= 1'b1;
      ibyte_data <= ib[k];
      k <= k + 2'h1;
    end
    else if (mem_req && !mem_vld && go)
    begin
      mem_vld <= 1'b1;
      mem_data <= mem[mem_addr[8:0]];
    end
  end
endmodule : oag_far
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import oag_pkg::*;
  logic ref_clk = 0, rst = 1, dec_start = 0, dec_use_y = 0, slow = 0;
  oag_mode_t dec_mode = OAG_INHERENT;
  oag_cls_t dec_cls = OAG_CLS_LOAD;
  logic [15:0] dec_pc = 16'h1000, pc_v = 16'h1000, mem_addr, ea_addr;
  logic [7:0] idx_x = 8'h00, idx_y = 8'h00, x_v = 8'h00, y_v = 8'h00;
  logic [7:0] ibyte_data, mem_data, ea_imm;
  logic ibyte_req, ibyte_vld, mem_req, mem_vld, ea_done, ea_is_imm;
  logic ea_illegal;
  logic [2:0] ea_len;
  int miscompares = 0, n_checks = 0;
  always #4 ref_clk = ~ref_clk;
  oag_core oag_core_i (.ref_clk, .rst, .dec_start, .dec_mode, .dec_cls,
    .dec_use_y, .dec_pc, .idx_x, .idx_y, .ibyte_req, .ibyte_vld,
    .ibyte_data, .mem_req, .mem_addr, .mem_vld, .mem_data, .ea_done,
    .ea_addr, .ea_imm, .ea_is_imm, .ea_len, .ea_illegal);
  oag_far oag_far_i (.ref_clk, .rst, .restart(dec_start), .slow,
    .ibyte_req, .ibyte_vld, .ibyte_data, .mem_req, .mem_addr, .mem_vld,
    .mem_data);
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic go(oag_mode_t m, oag_cls_t c, logic y, logic [7:0] b0,
                    logic [7:0] b1, logic [15:0] ea, logic [2:0] n);
    int i;
    oag_far_i.ib[0] = b0;
    oag_far_i.ib[1] = b1;
    @(posedge ref_clk);
    dec_mode <= m;
    dec_cls <= c;
    dec_use_y <= y;
    dec_pc <= pc_v;
    idx_x <= x_v;
    idx_y <= y_v;
    dec_start <= 1'b1;
    @(posedge ref_clk);
    dec_start <= 1'b0;
    i = 0;
    do
    begin
      @(negedge ref_clk);
      i++;
    end
    while (ea_done !== 1'b1 && i < 60);
    chk("done", 16'h0001, {15'h0000, ea_done});
    chk("length", {13'h0, n}, {13'h0, ea_len});
    chk("imm flag", {15'h0, m == OAG_IMMEDIATE},
        {15'h0, ea_is_imm});
    if (m == OAG_IMMEDIATE)
      chk("immediate", {8'h00, b0}, {8'h00, ea_imm});
    else if (m != OAG_INHERENT)
      chk("address", ea, ea_addr);
  endtask : go
  task automatic t_short;
    go(OAG_INHERENT, OAG_CLS_LOAD, 0, 8'h00, 8'h00, 16'h0, 1);
    go(OAG_IMMEDIATE, OAG_CLS_LOAD, 0, 8'hA5, 8'h00, 16'h0, 2);
    go(OAG_DIR_SHORT, OAG_CLS_LOAD, 0, 8'h9A, 8'h00, 16'h009A, 2);
    go(OAG_DIR_LONG, OAG_CLS_LOAD, 0, 8'h12, 8'h34, 16'h1234, 3);
    $display("direct test done");
  endtask : t_short
  task automatic t_index;
    x_v = 8'hF0;
    y_v = 8'h3C;
    go(OAG_IDX_NOOFF, OAG_CLS_LOAD, 0, 8'h00, 8'h00, 16'h00F0, 1);
    go(OAG_IDX_NOOFF, OAG_CLS_LOAD, 1, 8'h00, 8'h00, 16'h003C, 2);
    x_v = 8'hFF;
    go(OAG_IDX_SHORT, OAG_CLS_LOAD, 0, 8'hFF, 8'h00, 16'h01FE, 2);
    go(OAG_IDX_LONG, OAG_CLS_LOAD, 1, 8'h12, 8'hF0, 16'h132C, 4);
    $display("indexed test done");
  endtask : t_index
  task automatic t_indirect;
    oag_far_i.mem[9'h040] = 8'hC3;
    oag_far_i.mem[9'h0FF] = 8'hAB;
    oag_far_i.mem[9'h100] = 8'hCD;
    x_v = 8'h80;
    go(OAG_IND_SHORT, OAG_CLS_LOAD, 0, 8'h40, 8'h00, 16'h00C3, 3);
    slow = 1'b1;
    go(OAG_IND_LONG, OAG_CLS_LOAD, 0, 8'hFF, 8'h00, 16'hABCD, 3);
    slow = 1'b0;
    go(OAG_INDIDX_SHORT, OAG_CLS_LOAD, 0, 8'h40, 8'h0, 16'h143, 3);
    go(OAG_INDIDX_LONG, OAG_CLS_LOAD, 0, 8'hFF, 8'h0, 16'hAC4D, 3);
    $display("indirect test done");
  endtask : t_indirect
  task automatic t_branch;
    go(OAG_REL_DIR, OAG_CLS_JUMP, 0, 8'h80, 8'h00, 16'h0F82, 2);
    go(OAG_REL_DIR, OAG_CLS_JUMP, 0, 8'h7F, 8'h00, 16'h1081, 2);
    pc_v = 16'h2000;
    go(OAG_REL_IND, OAG_CLS_JUMP, 0, 8'h40, 8'h00, 16'h1FC6, 3);
    go(OAG_DIR_SHORT, OAG_CLS_RMW, 0, 8'h10, 8'h00, 16'h0010, 2);
    chk("flag", 16'h0, {15'h0, ea_illegal});
    go(OAG_DIR_LONG, OAG_CLS_RMW, 0, 8'h12, 8'h34, 16'h1234, 3);
    chk("flag", 16'h1, {15'h0, ea_illegal});
    $display("branch test done");
  endtask : t_branch
  task automatic t_bit;
    go(OAG_BIT_DIR, OAG_CLS_RMW, 0, 8'h55, 8'h00, 16'h0055, 2);
    chk("flag", 16'h0, {15'h0, ea_illegal});
    go(OAG_BIT_IND, OAG_CLS_RMW, 0, 8'h40, 8'h00, 16'h00C3, 3);
    go(OAG_BITREL_DIR, OAG_CLS_RMW, 0, 8'h20, 8'hF0, 16'h0020, 3);
    chk("offset", 16'h00F0, {8'h00, ea_imm});
    go(OAG_BITREL_IND, OAG_CLS_RMW, 0, 8'h40, 8'h10, 16'h00C3, 4);
    chk("offset", 16'h0010, {8'h00, ea_imm});
    $display("bit test done");
  endtask : t_bit
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_short;
    t_index;
    t_indirect;
    t_branch;
    t_bit;
    complete_run;
  end
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    complete_run;
  end
endmodule : tb
`default_nettype wire
